// File: tb/dsi_assertions.sv
`timescale 1ns/100ps
module dsi_assertions
(
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic       dbg_rx_wr,
    input wire logic       dbg_tx_rd,
    input wire logic       core_rx_rd,
    input wire logic       core_tx_wr,
    input wire logic       comms_rx_full,
    input wire logic       comms_tx_empty,
    input wire logic       debug_feature_enable,
    input wire logic       ext_halt_request,
    input wire logic [2:0] debug_ctrl,
    input wire logic       internal_halt_request,
    input wire logic       halt_acknowledge,
    input wire logic       exec_valid,
    input wire logic       exec_cond_pass,
    input wire logic       instr_complete,
    input wire logic       instr_executed,
    input wire logic       tracking_mode,
    input wire logic       tracking_active
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // request seen while enabled, then acknowledged
    sequence s_held_req;
        ext_halt_request && debug_feature_enable ##1 halt_acknowledge;
    endsequence
    sequence s_entry;
        !halt_acknowledge ##1 halt_acknowledge;
    endsequence

    property p_rx_set;
        dbg_rx_wr && (!comms_rx_full || core_rx_rd) |=> comms_rx_full;
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("receive flag not set after write");
    property p_rx_clr;
        core_rx_rd && !dbg_rx_wr |=> !comms_rx_full;
    endproperty
    a_rx_clr: assert property (p_rx_clr)
        else $error("receive flag not cleared after read");
    property p_tx_set;
        core_tx_wr && (comms_tx_empty || dbg_tx_rd) |=> !comms_tx_empty;
    endproperty
    a_tx_set: assert property (p_tx_set)
        else $error("transmit flag still empty after write");
    property p_tx_clr;
        dbg_tx_rd && !core_tx_wr |=> comms_tx_empty;
    endproperty
    a_tx_clr: assert property (p_tx_clr)
        else $error("transmit flag not empty after drain");
    property p_ack_held;
        s_held_req |=> halt_acknowledge;
    endproperty
    a_ack_held: assert property (p_ack_held)
        else $error("acknowledge dropped while request held");
    property p_no_entry;
        !debug_feature_enable [*2] |=> !$rose(halt_acknowledge);
    endproperty
    a_no_entry: assert property (p_no_entry)
        else $error("debug entry with features disabled");
    property p_halt_req;
        internal_halt_request == $past((ext_halt_request | debug_ctrl[1]) & debug_feature_enable);
    endproperty
    a_halt_req: assert property (p_halt_req)
        else $error("internal halt request mismatch");
    property p_entry_done;
        s_entry |-> $past(instr_complete);
    endproperty
    a_entry_done: assert property (p_entry_done)
        else $error("debug entry without instruction completion");
    property p_exec;
        !(exec_valid && exec_cond_pass) |=> !instr_executed;
    endproperty
    a_exec: assert property (p_exec)
        else $error("executed flag without passing instruction");
    property p_track;
        tracking_mode |=> tracking_active;
    endproperty
    a_track: assert property (p_track)
        else $error("tracking mode not entered");
endmodule

bind dsi_top dsi_assertions u_dsi_assertions (.*);

// File: tb/dsi_dbg_host.sv
`timescale 1ns/100ps
// external debugger halt side: raises a request, holds it LAG+1 acknowledged cycles
module dsi_dbg_host
#(
    parameter int LAG = 3
)
(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic go,
    input  wire logic halt_acknowledge,
    output logic      ext_halt_request
);
    logic     req_q;
    int       cnt_q;

    // release only LAG+1 cycles after acknowledge, a slow debugger
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_q <= 1'b0;
            cnt_q <= 0;
        end
        else if (go)
            req_q <= 1'b1;
        else if (req_q && halt_acknowledge)
        begin
            cnt_q <= (cnt_q == LAG) ? 0 : cnt_q + 1;
            if (cnt_q == LAG)
                req_q <= 1'b0;
        end
    end
    assign ext_halt_request = req_q;
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
`include "dsi_consts.svh"
module tb
    import dsi_pkg::*;
;
    logic clock, arst_n, dbg_rx_wr, dbg_tx_rd, core_rx_rd, core_tx_wr, host_go;
    logic comms_rx_full, comms_tx_empty, debug_feature_enable, ext_halt_request;
    logic debug_restart, internal_halt_request, halt_acknowledge, exec_valid;
    logic exec_cond_pass, instr_complete, instr_executed, ext_data_watch;
    logic ext_instr_break, watch0_ext_cond, watch1_ext_cond, watch0_match;
    logic watch1_match, tracking_mode, tracking_active;
    logic [`DSI_WORD_W-1:0] dbg_rx_wdata, dbg_tx_rdata, core_rx_rdata;
    logic [`DSI_WORD_W-1:0] core_tx_wdata, bus_addr, bus_data;
    logic [`DSI_CTRL_W-1:0] bus_ctrl;
    logic [`DSI_DBGCTL_W-1:0] debug_ctrl;
    dsi_cause_e debug_cause;
    logic [`DSI_WP_UNITS-1:0][`DSI_WORD_W-1:0] wp_addr_val, wp_addr_mask;
    logic [`DSI_WP_UNITS-1:0][`DSI_WORD_W-1:0] wp_data_val, wp_data_mask;
    logic [`DSI_WP_UNITS-1:0][`DSI_CTRL_W-1:0] wp_ctrl_val, wp_ctrl_mask;
    logic [`DSI_WP_UNITS-1:0] wp_ext_val, wp_ext_mask, wp_enable, wp_is_break;
    int num_errors, checks_done, cycles;

    dsi_top dut (.*);
    dsi_dbg_host #(.LAG(3)) host (.clock(clock), .arst_n(arst_n), .go(host_go),
        .halt_acknowledge(halt_acknowledge), .ext_halt_request(ext_halt_request));

    always #25 clock = ~clock;

    // hang guard, tests need about a hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            complete_run();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bounded wait on the acknowledge level
    task automatic wait_ack(input logic v);
        int n;
        n = 0;
        while (halt_acknowledge !== v && n < 30)
        begin
            tick(1);
            n++;
        end
        chk(halt_acknowledge, v);
    endtask

    task automatic enter(input dsi_cause_e c);
        instr_complete <= 1'b1;
        tick(1);
        instr_complete <= 1'b0;
        wait_ack(1'b1);
        chk(debug_cause, c);
    endtask

    task automatic leave();
        debug_restart <= 1'b1;
        tick(1);
        debug_restart <= 1'b0;
        wait_ack(1'b0);
    endtask

    task automatic complete_run();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        {clock, arst_n, dbg_rx_wr, dbg_tx_rd, core_rx_rd, core_tx_wr, host_go} = '0;
        {debug_restart, exec_valid, exec_cond_pass, instr_complete, ext_data_watch} = '0;
        {ext_instr_break, watch0_ext_cond, watch1_ext_cond, tracking_mode} = '0;
        {dbg_rx_wdata, core_tx_wdata, bus_addr, bus_data, bus_ctrl, debug_ctrl} = '0;
        {wp_addr_val, wp_data_val, wp_ctrl_val, wp_enable, wp_is_break, wp_ext_mask} = '0;
        {wp_addr_mask, wp_data_mask, wp_ctrl_mask, wp_ext_val} = '1;
        debug_feature_enable = 1'b1;
        tick(20);
        arst_n <= 1'b1;
        tick(1);
        chk({comms_rx_full, comms_tx_empty, halt_acknowledge}, 3'b010);
        // receive word, a dropped write, read and write on one edge
        dbg_rx_wr <= 1'b1;
        dbg_rx_wdata <= 32'hA5A5_0001;
        tick(1);
        dbg_rx_wdata <= 32'h0000_0BAD;
        tick(1);
        dbg_rx_wr <= 1'b0;
        tick(1);
        chk({comms_rx_full, core_rx_rdata}, 33'h1_A5A5_0001);
        core_rx_rd <= 1'b1;
        dbg_rx_wr <= 1'b1;
        dbg_rx_wdata <= 32'h5A5A_0002;
        tick(1);
        dbg_rx_wr <= 1'b0;
        tick(1);
        core_rx_rd <= 1'b0;
        chk({comms_rx_full, core_rx_rdata}, 33'h1_5A5A_0002);
        tick(1);
        chk(comms_rx_full, 1'b0);
        // transmit word out and drained
        core_tx_wr <= 1'b1;
        core_tx_wdata <= 32'h1234_ABCD;
        tick(1);
        core_tx_wr <= 1'b0;
        tick(1);
        chk({comms_tx_empty, dbg_tx_rdata}, 33'h0_1234_ABCD);
        dbg_tx_rd <= 1'b1;
        tick(1);
        dbg_tx_rd <= 1'b0;
        tick(1);
        chk(comms_tx_empty, 1'b1);
        // executed flag follows the condition pass a cycle late
        exec_valid <= 1'b1;
        exec_cond_pass <= 1'b1;
        tick(2);
        chk(instr_executed, 1'b1);
        exec_cond_pass <= 1'b0;
        tick(2);
        chk(instr_executed, 1'b0);
        exec_cond_pass <= 1'b1;
        // debugger halt waits for the instruction to complete
        host_go <= 1'b1;
        tick(1);
        host_go <= 1'b0;
        tick(6);
        chk({internal_halt_request, halt_acknowledge}, 2'b10);
        enter(DSI_CAUSE_HALT);
        tick(1);
        chk(instr_executed, 1'b0);
        tick(6);
        leave();
        // control bit halt, blocked while features disabled
        debug_feature_enable <= 1'b0;
        debug_ctrl <= 3'h2;
        instr_complete <= 1'b1;
        tick(4);
        instr_complete <= 1'b0;
        chk({internal_halt_request, halt_acknowledge}, 2'b00);
        debug_feature_enable <= 1'b1;
        tick(2);
        chk(internal_halt_request, 1'b1);
        enter(DSI_CAUSE_HALT);
        debug_ctrl <= 3'h0;
        tick(3);
        leave();
        // condition inputs reach their own unit, enables off
        watch0_ext_cond <= 1'b1;
        tick(2);
        chk({watch0_match, watch1_match}, 2'b10);
        watch0_ext_cond <= 1'b0;
        watch1_ext_cond <= 1'b1;
        tick(2);
        chk({watch0_match, watch1_match}, 2'b01);
        // exact bus compare on unit 0, unit 1 matches anything
        wp_ext_mask <= 2'b11;
        {wp_addr_mask[0], wp_data_mask[0], wp_ctrl_mask[0]} <= '0;
        {bus_addr, wp_addr_val[0]} <= {2{32'h0000_1234}};
        {bus_data, wp_data_val[0]} <= {2{32'h0000_00A5}};
        {bus_ctrl, wp_ctrl_val[0]} <= {2{4'h3}};
        tick(2);
        chk({watch0_match, watch1_match}, 2'b11);
        bus_addr <= 32'h0000_1235;
        tick(2);
        chk({watch0_match, watch1_match}, 2'b01);
        // external break, external watch, armed unit as break
        for (int i = 0; i < 3; i++)
        begin
            ext_instr_break <= (i == 0);
            ext_data_watch <= (i == 1);
            wp_enable <= (i == 2) ? 2'b10 : 2'b00;
            wp_is_break <= 2'b10;
            tick(1);
            {ext_instr_break, ext_data_watch} <= 2'b00;
            tick(3);
            enter((i == 1) ? DSI_CAUSE_WATCH : DSI_CAUSE_BREAK);
            wp_enable <= 2'b00;
            tick(2);
            leave();
        end
        tracking_mode <= 1'b1;
        tick(2);
        chk(tracking_active, 1'b1);
        tracking_mode <= 1'b0;
        tick(2);
        chk(tracking_active, 1'b0);
        complete_run();
    end
endmodule

// File: verilog/dsi_comms.sv
`timescale 1ns/100ps
`include "dsi_consts.svh"
module dsi_comms
    import dsi_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  arst_n,
    dsi_comms_if.chan  ch
);
    dsi_word_t rx_word_q;
    dsi_word_t rx_word_d;
    logic      rx_full_q;
    logic      rx_full_d;
    dsi_word_t tx_word_q;
    dsi_word_t tx_word_d;
    logic      tx_empty_q;
    logic      tx_empty_d;
    logic      rx_take;
    logic      tx_take;

    // a write into a held word is refused unless the word is drained that same cycle
    always_comb
    begin
        rx_take   = ch.rx_wr && (!rx_full_q || ch.rx_rd);
        tx_take   = ch.tx_wr && (tx_empty_q || ch.tx_rd);
        rx_word_d = rx_take ? ch.rx_wdata : rx_word_q;
        tx_word_d = tx_take ? ch.tx_wdata : tx_word_q;
        rx_full_d = rx_full_q;
        if (rx_take)
            rx_full_d = 1'b1;                 // set beats clear
        else if (ch.rx_rd)
            rx_full_d = 1'b0;
        tx_empty_d = tx_empty_q;
        if (tx_take)
            tx_empty_d = 1'b0;                // pending word wins
        else if (ch.tx_rd)
            tx_empty_d = 1'b1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_word_q  <= `DSI_WORD_RST;
            tx_word_q  <= `DSI_WORD_RST;
            rx_full_q  <= 1'b0;
            tx_empty_q <= 1'b1;
        end
        else
        begin
            rx_word_q  <= rx_word_d;
            tx_word_q  <= tx_word_d;
            rx_full_q  <= rx_full_d;
            tx_empty_q <= tx_empty_d;
        end
    end

    assign ch.rx_rdata = rx_word_q;
    assign ch.tx_rdata = tx_word_q;
    assign ch.rx_full  = rx_full_q;
    assign ch.tx_empty = tx_empty_q;
endmodule

// File: verilog/dsi_consts.svh
`ifndef DSI_CONSTS_SVH
`define DSI_CONSTS_SVH
// Notes on behaviour
// - comms_rx_full is high while the receive word holds data the core has not read yet.
// - comms_tx_empty is high while the transmit word holds no pending data.
// - halt_acknowledge is high exactly while the core is in debug state and low otherwise.
// - debug_feature_enable low disables debug entry, and the far side drives it low only when no debugging is wanted.
// - internal_halt_request is the halt request given to the core: the external request or control bit 1, gated by debug_feature_enable.
// - an external halt request enters debug state once the current instruction completes, never aborting it.
// - condition input 0 feeds watch unit 0 and condition input 1 feeds watch unit 1.
// - external data watch and external instruction break inputs flag accesses and instructions for debug entry.
// - instr_executed says the execute-stage instruction passed its condition codes and ran in the previous cycle.
// - each watch match output follows its unit's comparison on the buses, whatever the unit enable.
// - driving tracking_mode high puts the processor into tracking mode.

`define DSI_WORD_W    32
`define DSI_CTRL_W    4
`define DSI_DBGCTL_W  3
`define DSI_HALT_BIT  1
`define DSI_WP_UNITS  2
`define DSI_WORD_RST  32'h0000_0000
`endif

// File: verilog/dsi_if.sv
`timescale 1ns/100ps
`include "dsi_consts.svh"
// one watch unit: buses and setup in, match out
interface dsi_watch_if;
    logic [`DSI_WORD_W-1:0] addr;
    logic [`DSI_WORD_W-1:0] data;
    logic [`DSI_CTRL_W-1:0] ctrl;
    logic [`DSI_WORD_W-1:0] addr_val;
    logic [`DSI_WORD_W-1:0] addr_mask;
    logic [`DSI_WORD_W-1:0] data_val;
    logic [`DSI_WORD_W-1:0] data_mask;
    logic [`DSI_CTRL_W-1:0] ctrl_val;
    logic [`DSI_CTRL_W-1:0] ctrl_mask;
    logic                   ext_val;
    logic                   ext_mask;
    logic                   ext_cond;
    logic                   match;
    modport unit (input addr, data, ctrl, addr_val, addr_mask, data_val, data_mask,
                  input ctrl_val, ctrl_mask, ext_val, ext_mask, ext_cond, output match);
    modport top  (output addr, data, ctrl, addr_val, addr_mask, data_val, data_mask,
                  output ctrl_val, ctrl_mask, ext_val, ext_mask, ext_cond, input match);
endinterface

// one-word comms channel, both directions
interface dsi_comms_if;
    logic                   rx_wr;
    logic [`DSI_WORD_W-1:0] rx_wdata;
    logic                   rx_rd;
    logic [`DSI_WORD_W-1:0] rx_rdata;
    logic                   rx_full;
    logic                   tx_wr;
    logic [`DSI_WORD_W-1:0] tx_wdata;
    logic                   tx_rd;
    logic [`DSI_WORD_W-1:0] tx_rdata;
    logic                   tx_empty;
    modport chan (input rx_wr, rx_wdata, rx_rd, tx_wr, tx_wdata, tx_rd,
                  output rx_rdata, rx_full, tx_rdata, tx_empty);
    modport top  (output rx_wr, rx_wdata, rx_rd, tx_wr, tx_wdata, tx_rd,
                  input rx_rdata, rx_full, tx_rdata, tx_empty);
endinterface

// File: verilog/dsi_pkg.sv
`include "dsi_consts.svh"
package dsi_pkg;
    typedef logic [`DSI_WORD_W-1:0] dsi_word_t;
    typedef logic [`DSI_CTRL_W-1:0] dsi_ctrl_t;

    // core run state as seen by the debug logic
    typedef enum logic [1:0] {DSI_RUN, DSI_PEND, DSI_HALTED} dsi_state_e;

    // reason for the last debug entry
    typedef enum logic [1:0] {DSI_CAUSE_NONE, DSI_CAUSE_HALT, DSI_CAUSE_BREAK,
                              DSI_CAUSE_WATCH} dsi_cause_e;

    // masked equality: a set mask bit means "don't care"
    function automatic logic dsi_masked_eq(input dsi_word_t a,
                                           input dsi_word_t b,
                                           input dsi_word_t m);
        dsi_masked_eq = (((a ^ b) & ~m) == `DSI_WORD_RST);
    endfunction
endpackage

// File: verilog/dsi_top.sv
`timescale 1ns/100ps
`include "dsi_consts.svh"
module dsi_top
    import dsi_pkg::*;
(
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    // comms channel, debugger side
    input  wire logic                          dbg_rx_wr,
    input  wire logic [`DSI_WORD_W-1:0]        dbg_rx_wdata,
    input  wire logic                          dbg_tx_rd,
    output logic      [`DSI_WORD_W-1:0]        dbg_tx_rdata,

    // comms channel, core side
    input  wire logic                          core_rx_rd,
    output logic      [`DSI_WORD_W-1:0]        core_rx_rdata,
    input  wire logic                          core_tx_wr,
    input  wire logic [`DSI_WORD_W-1:0]        core_tx_wdata,
    output logic                               comms_rx_full,
    output logic                               comms_tx_empty,

    // halt control
    input  wire logic                          debug_feature_enable,
    input  wire logic                          ext_halt_request,
    input  wire logic [`DSI_DBGCTL_W-1:0]      debug_ctrl,
    input  wire logic                          debug_restart,
    output logic                               internal_halt_request,
    output logic                               halt_acknowledge,
    output dsi_cause_e                         debug_cause,

    // core pipeline status
    input  wire logic                          exec_valid,
    input  wire logic                          exec_cond_pass,
    input  wire logic                          instr_complete,
    output logic                               instr_executed,

    // external break and watch
    input  wire logic                          ext_data_watch,
    input  wire logic                          ext_instr_break,
    input  wire logic                          watch0_ext_cond,
    input  wire logic                          watch1_ext_cond,

    // buses watched by both units
    input  wire logic [`DSI_WORD_W-1:0]        bus_addr,
    input  wire logic [`DSI_WORD_W-1:0]        bus_data,
    input  wire logic [`DSI_CTRL_W-1:0]        bus_ctrl,

    // watch unit setup, index is the unit
    input  wire logic [`DSI_WP_UNITS-1:0][`DSI_WORD_W-1:0] wp_addr_val,
    input  wire logic [`DSI_WP_UNITS-1:0][`DSI_WORD_W-1:0] wp_addr_mask,
    input  wire logic [`DSI_WP_UNITS-1:0][`DSI_WORD_W-1:0] wp_data_val,
    input  wire logic [`DSI_WP_UNITS-1:0][`DSI_WORD_W-1:0] wp_data_mask,
    input  wire logic [`DSI_WP_UNITS-1:0][`DSI_CTRL_W-1:0] wp_ctrl_val,
    input  wire logic [`DSI_WP_UNITS-1:0][`DSI_CTRL_W-1:0] wp_ctrl_mask,
    input  wire logic [`DSI_WP_UNITS-1:0]      wp_ext_val,
    input  wire logic [`DSI_WP_UNITS-1:0]      wp_ext_mask,
    input  wire logic [`DSI_WP_UNITS-1:0]      wp_enable,
    input  wire logic [`DSI_WP_UNITS-1:0]      wp_is_break,
    output logic                               watch0_match,
    output logic                               watch1_match,

    // tracking
    input  wire logic                          tracking_mode,
    output logic                               tracking_active
);
    // one sequencer owns debug state; comms words sit apart,
    // watch units sit beside it and only feed it hits

    // comms bundle and per-unit results
    dsi_comms_if                 comms ();
    logic [`DSI_WP_UNITS-1:0]    unit_match;
    logic [`DSI_WP_UNITS-1:0]    ext_cond;

    // sequencer state
    dsi_state_e state_q;
    dsi_state_e state_d;

    // cause of the last entry, held till the next
    dsi_cause_e cause_q;
    dsi_cause_e cause_d;

    // cause waiting for the instruction to finish
    dsi_cause_e pend_q;
    dsi_cause_e pend_d;

    // halt request as shown to the core
    logic       req_q;
    logic       req_d;

    // acknowledge from a flop, never glitches
    logic       ack_q;
    logic       ack_d;

    // executed flag, a cycle behind execute
    logic       exec_q;
    logic       exec_d;

    // tracking pin copy
    logic       track_q;
    logic       track_d;

    // merged entry sources
    logic       halt_src;
    logic       break_hit;
    logic       watch_hit;

    // comms channel wiring
    // each word has one writer and one reader:
    // debugger fills receive, core fills transmit
    assign comms.rx_wr    = dbg_rx_wr;
    assign comms.rx_wdata = dbg_rx_wdata;
    assign comms.rx_rd    = core_rx_rd;
    assign comms.tx_wr    = core_tx_wr;
    assign comms.tx_wdata = core_tx_wdata;
    assign comms.tx_rd    = dbg_tx_rd;

    // words and flags read back
    assign core_rx_rdata  = comms.rx_rdata;
    assign dbg_tx_rdata   = comms.tx_rdata;
    assign comms_rx_full  = comms.rx_full;
    assign comms_tx_empty = comms.tx_empty;

    dsi_comms u_comms
    (
        .clock  (clock),
        .arst_n (arst_n),
        .ch     (comms)
    );

    // condition input n goes to unit n only
    // a swapped pair would cross the unit conditions
    assign ext_cond = {watch1_ext_cond, watch0_ext_cond};

    // two watch units on the same buses
    // units are registered: one cycle of latency
    // keeps the wide compare off the sequencer path
    for (genvar u = 0; u < `DSI_WP_UNITS; u++)
    begin : g_unit
        // buses shared, setup per unit
        dsi_watch_if wif ();
        assign wif.addr      = bus_addr;
        assign wif.data      = bus_data;
        assign wif.ctrl      = bus_ctrl;
        assign wif.addr_val  = wp_addr_val[u];
        assign wif.addr_mask = wp_addr_mask[u];
        assign wif.data_val  = wp_data_val[u];
        assign wif.data_mask = wp_data_mask[u];
        assign wif.ctrl_val  = wp_ctrl_val[u];
        assign wif.ctrl_mask = wp_ctrl_mask[u];
        assign wif.ext_val   = wp_ext_val[u];
        assign wif.ext_mask  = wp_ext_mask[u];
        assign wif.ext_cond  = ext_cond[u];

        assign unit_match[u] = wif.match;

        dsi_watch u_watch
        (
            .clock  (clock),
            .arst_n (arst_n),
            .wp     (wif)
        );
    end

    // match pins ignore both enables
    assign watch0_match = unit_match[0];
    assign watch1_match = unit_match[1];

    // entry sources; an armed unit counts, a disarmed one only shows its match
    // pin and control bit merge here; the enable
    // gates the registered copy seen by the core
    always_comb
    begin
        halt_src  = ext_halt_request || debug_ctrl[`DSI_HALT_BIT];
        // enabled units split by their break flag
        break_hit = ext_instr_break
                 || |(unit_match & wp_enable & wp_is_break);
        watch_hit = ext_data_watch
                 || |(unit_match & wp_enable & ~wp_is_break);
    end

    // halt sequencing: requests and hits wait for the running instruction to finish
    // run: break beats watch beats request, so the
    //      cause names the most specific reason
    // pend: taken on the instr_complete edge, so
    //       the core never stops mid-instruction
    // pend: losing the enable drops the entry
    // halted: restart refused while a request is
    //         held, so a slow debugger keeps it
    // limitation: hits in pend or halted are lost
    always_comb
    begin
        // hold by default, every path assigns
        state_d = state_q;
        cause_d = cause_q;
        pend_d  = pend_q;
        req_d   = debug_feature_enable && halt_src;

        case (state_q)
            // entry only with the features on
            DSI_RUN:
            begin
                if (debug_feature_enable)
                begin
                    // break first, then watch, then request
                    if (break_hit)
                    begin
                        pend_d  = DSI_CAUSE_BREAK;
                        state_d = DSI_PEND;
                    end
                    else if (watch_hit)
                    begin
                        pend_d  = DSI_CAUSE_WATCH;
                        state_d = DSI_PEND;
                    end
                    else if (req_q)
                    begin
                        pend_d  = DSI_CAUSE_HALT;
                        state_d = DSI_PEND;
                    end
                end
            end

            // wait out the running instruction
            DSI_PEND:
            begin
                if (!debug_feature_enable)
                begin
                    pend_d  = DSI_CAUSE_NONE;
                    state_d = DSI_RUN;
                end
                else if (instr_complete)
                begin
                    cause_d = pend_q;
                    pend_d  = DSI_CAUSE_NONE;
                    state_d = DSI_HALTED;
                end
            end

            DSI_HALTED:
            begin
                // a request still held blocks the restart, so the core stays halted
                if (debug_restart && !req_q)
                    state_d = DSI_RUN;
            end

            // unused code, back to run
            default:
                state_d = DSI_RUN;
        endcase

        // registered, so ack tracks state_q exactly
        ack_d = (state_d == DSI_HALTED);
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // running, nothing pending or held
            state_q <= DSI_RUN;
            cause_q <= DSI_CAUSE_NONE;
            pend_q  <= DSI_CAUSE_NONE;
            req_q   <= 1'b0;
            ack_q   <= 1'b0;
        end
        else
        begin
            // every flop loads each edge
            state_q <= state_d;
            cause_q <= cause_d;
            pend_q  <= pend_d;
            req_q   <= req_d;
            ack_q   <= ack_d;
        end
    end

    // outputs straight from flops
    assign internal_halt_request = req_q;
    assign halt_acknowledge      = ack_q;
    assign debug_cause           = cause_q;

    // executed flag trails the execute stage by one cycle
    // a halted core executes nothing, so the flag
    // stays low; tracking is a plain flop copy
    always_comb
    begin
        exec_d  = exec_valid && exec_cond_pass && (state_q != DSI_HALTED);
        track_d = tracking_mode;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // nothing executed, tracking off
            exec_q  <= 1'b0;
            track_q <= 1'b0;
        end
        else
        begin
            // plain registers, no enable
            exec_q  <= exec_d;
            track_q <= track_d;
        end
    end

    assign instr_executed  = exec_q;
    assign tracking_active = track_q;
endmodule

// File: verilog/dsi_watch.sv
`timescale 1ns/100ps
`include "dsi_consts.svh"
module dsi_watch
    import dsi_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  arst_n,
    dsi_watch_if.unit  wp
);
    logic match_q;
    logic match_d;

    // the unit enable is not looked at here, so the match shows even when disarmed
    always_comb
    begin
        match_d = dsi_masked_eq(wp.addr, wp.addr_val, wp.addr_mask)
               && dsi_masked_eq(wp.data, wp.data_val, wp.data_mask)
               && ((((wp.ctrl ^ wp.ctrl_val) & ~wp.ctrl_mask) == '0))
               && (wp.ext_mask || (wp.ext_cond == wp.ext_val));
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            match_q <= 1'b0;
        else
            match_q <= match_d;
    end

    assign wp.match = match_q;
endmodule
